/* src/lsm_pkg.sv */
// Package with register map, field layout and timing constants of the display setup block
package lsm_pkg;
    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] LSM_IDX_CONFIG = 10'h095;
    localparam logic [9:0] LSM_IDX_FRAME = 10'h096;
    localparam logic [9:0] LSM_IDX_SEG_HIGH = 10'h097;
    localparam logic [9:0] LSM_IDX_POINTER = 10'h0ac;
    localparam logic [9:0] LSM_IDX_DATA = 10'h0ae;
    localparam logic [9:0] LSM_IDX_SEG_LOW = 10'h0ed;
    localparam int LSM_ADDR_W = 12;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int LSM_CFG_CLEAR_BIT = 6;
    localparam int LSM_CFG_SLOW_BIT = 3;
    localparam int LSM_CFG_BIAS_BIT = 2;
    localparam logic [7:0] LSM_CFG_KEEP_MASK = 8'h3f;
    localparam logic [7:0] LSM_SEG_HIGH_MASK = 8'hfc;
    localparam logic [7:0] LSM_SEG_LOW_MASK = 8'h0f;
    localparam logic [7:0] LSM_PTR_MASK = 8'hbf;
    localparam int LSM_PTR_WRITE_BIT = 7;
    localparam logic [7:0] LSM_RESET_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // Display memory geometry
    // ----------------------------------------------------------------
    localparam int LSM_SCREENS = 4;
    localparam int LSM_BYTES = 15;
    localparam logic [3:0] LSM_LAST_ADDR = 4'he;

    // ----------------------------------------------------------------
    // Common count encodings and frame codes
    // ----------------------------------------------------------------
    localparam logic [1:0] LSM_MUX_THREE = 2'h2;
    localparam logic [1:0] LSM_MUX_FOUR = 2'h3;
    localparam logic [3:0] LSM_FD_FASTEST = 4'hf;
    localparam logic [3:0] LSM_FD_FAST = 4'h0;
    localparam logic [3:0] LSM_FD_TWO_A = 4'h1;
    localparam logic [3:0] LSM_FD_TWO_B = 4'h2;

    // Waveform period in slow clock ticks (128 Hz divided by waveform rate)
    localparam logic [3:0] LSM_DIV_128 = 4'h1;
    localparam logic [3:0] LSM_DIV_64 = 4'h2;
    localparam logic [3:0] LSM_DIV_32 = 4'h4;
    localparam logic [3:0] LSM_DIV_21 = 4'h6;
    localparam logic [3:0] LSM_DIV_16 = 4'h8;

    localparam int LSM_SEG_PINS = 26;
    localparam int LSM_FIXED_SEGS = 16;
endpackage

/* src/lsm_memory.sv */
// Display data memory: four screens of fifteen bytes held in flip-flops
`timescale 1ns/1ps
module lsm_memory
    import lsm_pkg::*;
#(
    parameter int SCREENS = LSM_SCREENS,
    parameter int BYTES = LSM_BYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [1:0] wr_screen,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_screen,
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic [1:0] disp_screen,
    input wire logic [3:0] disp_addr,
    output logic [7:0] disp_data
);
    logic [7:0] mem_r [SCREENS*BYTES];

    // ----------------------------------------------------------------
    // Storage, one entry per generate step
    // ----------------------------------------------------------------
    // Clear beats a write in the same cycle so a cleared screen stays blank
    for (genvar e = 0; e < SCREENS * BYTES; e++) begin : g_entry
        localparam logic [1:0] SCR = 2'(e / BYTES);
        localparam logic [3:0] ADR = 4'(e % BYTES);
        wire hit = wr_en && (wr_screen == SCR) && (wr_addr == ADR);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_r[e] <= LSM_RESET_BYTE; // see RL17
            end else if (clear) begin
                mem_r[e] <= LSM_RESET_BYTE; // see RL16
            end else if (hit) begin
                mem_r[e] <= wr_data; // see RL7
            end
        end
    end

    // Read ports; address 15 is outside the memory and reads as zero
    wire rd_ok = rd_addr <= LSM_LAST_ADDR;
    wire disp_ok = disp_addr <= LSM_LAST_ADDR;
    assign rd_data = rd_ok ? mem_r[32'(rd_screen) * BYTES + 32'(rd_addr)] : LSM_RESET_BYTE;
    assign disp_data = disp_ok ? mem_r[32'(disp_screen) * BYTES + 32'(disp_addr)] : LSM_RESET_BYTE;
endmodule

/* src/lsm_display_setup.sv */
// Display setup block: register file, pin routing, frame rate decode and memory access
//
// Notes on behaviour
// RL1 - Slow clock, two commons: codes 1,2,15,0 give 32,21.3,128,64 Hz; others 16 Hz.
// RL2 - Slow clock, three or four commons: 15 gives 128, 0 gives 64, others 32 Hz.
// RL3 - Config bit 3 set selects the 128 Hz display clock.
// RL4 - High select bits 7..2 route segments 25..20 to display or I/O; reset 0.
// RL5 - Software keeps high select bits 1..0 at zero.
// RL6 - Low select bits 3..0 route segments 19..16; upper bits reserved; reset 0.
// RL7 - Pointer bit 7 set writes the data register into the addressed byte.
// RL8 - Pointer bits 5..4 choose target screen; bit 6 reserved; reset zero.
// RL9 - Data register holds byte to write or byte read; resets to zero.
// RL10 - Software sets bias and common count to suit the attached glass.
// RL11 - Shared common two and three pins act as segments by default.
// RL12 - Common count 10 turns the segment 28 pin into common two.
// RL13 - Common count 11 also turns the segment 27 pin into common three.
// RL14 - Segments 0 to 15 are driven from reset without enables.
// RL15 - Each shared segment enable acts alone; any subset is allowed.
// RL16 - Setting config bit 6 clears all display memory.
// RL17 - Power-on reset clears all display memory.
// RL18 - Each pointer write selects screen and byte and starts the access.
// RL19 - Memory holds four screens of fifteen bytes, two segments per byte.
// RL20 - Pointer write with bit 7 clear loads the addressed byte into data.
// RL21 - Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
module lsm_display_setup
    import lsm_pkg::*;
#(
    parameter int SEG_PINS = LSM_SEG_PINS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [LSM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lcd_slow_clk,
    input wire logic [1:0] disp_screen,
    input wire logic [3:0] disp_addr,
    output logic [7:0] disp_data,
    output logic [SEG_PINS-1:0] seg_pin_select,
    output logic common_line_two,
    output logic common_line_three,
    output logic segment_line_28,
    output logic segment_line_27,
    output logic slow_clock_select,
    output logic bias_select,
    output logic [1:0] common_count_field,
    output logic [3:0] frame_rate_code,
    output logic [3:0] blink_config,
    output logic rate_valid,
    output logic [3:0] wave_div,
    output logic [4:0] frame_div,
    output logic wave_step,
    output logic frame_start,
    output logic [1:0] active_common
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] display_config_reg_r;
    logic [7:0] frame_reg_r;
    logic [7:0] segment_pin_select_high_r;
    logic [7:0] segment_pin_select_low_r;
    logic [7:0] display_memory_pointer_r;
    logic [7:0] display_memory_data_r;
    logic [7:0] display_memory_data_nxt;
    logic mem_clear_r;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Registers sit one per aligned word; the two low address bits are ignored
    wire [9:0] reg_idx = paddr[LSM_ADDR_W-1:2];
    wire hit_config = reg_idx == LSM_IDX_CONFIG;
    wire hit_frame = reg_idx == LSM_IDX_FRAME;
    wire hit_seg_high = reg_idx == LSM_IDX_SEG_HIGH;
    wire hit_pointer = reg_idx == LSM_IDX_POINTER;
    wire hit_data = reg_idx == LSM_IDX_DATA;
    wire hit_seg_low = reg_idx == LSM_IDX_SEG_LOW;
    wire hit_any = hit_config | hit_frame | hit_seg_high | hit_pointer | hit_data | hit_seg_low;
    wire access = psel && penable;
    wire wr_stb = access && pwrite && hit_any;
    wire [7:0] wbyte = pwdata[7:0];

    // Zero wait states; unmapped words answer with an error and no effect
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;

    // Read data mux over the register flops; upper bits always zero
    wire [7:0] rd_byte =
        hit_config ? display_config_reg_r :
        hit_frame ? frame_reg_r :
        hit_seg_high ? segment_pin_select_high_r :
        hit_pointer ? display_memory_pointer_r :
        hit_data ? display_memory_data_r :
        hit_seg_low ? segment_pin_select_low_r : LSM_RESET_BYTE;
    assign prdata = {24'h000000, rd_byte};

    // ----------------------------------------------------------------
    // Configuration and pin select registers
    // ----------------------------------------------------------------
    // Reserved bits are masked off at the write so they always read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_config_reg_r <= LSM_RESET_BYTE;
            frame_reg_r <= LSM_RESET_BYTE;
            segment_pin_select_high_r <= LSM_RESET_BYTE; // see RL4
            segment_pin_select_low_r <= LSM_RESET_BYTE; // see RL6
        end else if (wr_stb) begin
            if (hit_config) begin
                display_config_reg_r <= wbyte & LSM_CFG_KEEP_MASK; // see RL21
            end
            if (hit_frame) begin
                frame_reg_r <= wbyte;
            end
            if (hit_seg_high) begin
                segment_pin_select_high_r <= wbyte & LSM_SEG_HIGH_MASK; // see RL5
            end
            if (hit_seg_low) begin
                segment_pin_select_low_r <= wbyte & LSM_SEG_LOW_MASK; // see RL6
            end
        end
    end

    // Memory clear is an action bit: one cycle pulse, never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_clear_r <= 1'b0;
        end else begin
            mem_clear_r <= wr_stb && hit_config && wbyte[LSM_CFG_CLEAR_BIT]; // see RL16
        end
    end

    // ----------------------------------------------------------------
    // Indirect memory access
    // ----------------------------------------------------------------
    wire ptr_wr = wr_stb && hit_pointer;
    wire ptr_is_write = wbyte[LSM_PTR_WRITE_BIT];
    wire [1:0] ptr_screen = wbyte[5:4];
    wire [3:0] ptr_addr = wbyte[3:0];
    wire [7:0] mem_rd_data;

    // Pointer holds the last access; bit 6 is dropped on the way in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_memory_pointer_r <= LSM_RESET_BYTE; // see RL8
        end else if (ptr_wr) begin
            display_memory_pointer_r <= wbyte & LSM_PTR_MASK; // see RL8
        end
    end

    // Data register: software write, or load on a pointer read access
    always_comb begin
        display_memory_data_nxt = display_memory_data_r;
        if (wr_stb && hit_data) begin
            display_memory_data_nxt = wbyte; // see RL9
        end else if (ptr_wr && !ptr_is_write) begin
            display_memory_data_nxt = mem_rd_data; // see RL20
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_memory_data_r <= LSM_RESET_BYTE; // see RL9
        end else begin
            display_memory_data_r <= display_memory_data_nxt;
        end
    end

    // The write uses the data already held, at the very edge of the pointer write
    lsm_memory #(
        .SCREENS(LSM_SCREENS),
        .BYTES(LSM_BYTES)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .clear(mem_clear_r),
        .wr_en(ptr_wr && ptr_is_write), // see RL18
        .wr_screen(ptr_screen),
        .wr_addr(ptr_addr),
        .wr_data(display_memory_data_r), // see RL7
        .rd_screen(ptr_screen),
        .rd_addr(ptr_addr),
        .rd_data(mem_rd_data),
        .disp_screen(disp_screen),
        .disp_addr(disp_addr),
        .disp_data(disp_data) // see RL19
    );

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    // Low sixteen segments are always on the glass; shared pins follow their own bit
    assign seg_pin_select[LSM_FIXED_SEGS-1:0] = '1; // see RL14
    assign seg_pin_select[19:16] = segment_pin_select_low_r[3:0]; // see RL15
    assign seg_pin_select[25:20] = segment_pin_select_high_r[7:2]; // see RL15

    // Shared common pins stay segments until the common count asks for them
    assign common_count_field = display_config_reg_r[1:0];
    wire mux3 = common_count_field == LSM_MUX_THREE;
    wire mux4 = common_count_field == LSM_MUX_FOUR;
    assign common_line_two = mux3 || mux4; // see RL12
    assign common_line_three = mux4; // see RL13
    assign segment_line_28 = !common_line_two; // see RL11
    assign segment_line_27 = !common_line_three; // see RL11

    // Glass setup fields passed on to the waveform stage
    assign slow_clock_select = display_config_reg_r[LSM_CFG_SLOW_BIT]; // see RL3
    assign bias_select = display_config_reg_r[LSM_CFG_BIAS_BIT]; // see RL10
    assign frame_rate_code = frame_reg_r[3:0];
    assign blink_config = frame_reg_r[7:4];

    // ----------------------------------------------------------------
    // Frame rate decode for the slow display clock
    // ----------------------------------------------------------------
    // Only the slow clock table lives here; on the fast clock the rate is flagged invalid
    logic [3:0] div_sel;
    always_comb begin
        div_sel = LSM_DIV_32; // see RL2
        if (frame_rate_code == LSM_FD_FASTEST) begin
            div_sel = LSM_DIV_128; // see RL1
        end else if (frame_rate_code == LSM_FD_FAST) begin
            div_sel = LSM_DIV_64; // see RL1
        end else if (!common_line_two) begin
            if (frame_rate_code == LSM_FD_TWO_A) begin
                div_sel = LSM_DIV_32; // see RL1
            end else if (frame_rate_code == LSM_FD_TWO_B) begin
                div_sel = LSM_DIV_21; // see RL1
            end else begin
                div_sel = LSM_DIV_16; // see RL1
            end
        end
    end

    // Frame spans one waveform period per common line
    wire [2:0] commons = mux4 ? 3'h4 : (mux3 ? 3'h3 : 3'h2);
    wire [1:0] last_common = 2'(commons - 3'h1);
    assign rate_valid = slow_clock_select; // see RL3
    assign wave_div = div_sel;
    assign frame_div = 5'({1'b0, div_sel} * {2'b00, commons}); // see RL2

    // ----------------------------------------------------------------
    // Slow clock sampling and waveform stepping
    // ----------------------------------------------------------------
    // The slow clock comes from a pin, so it is synchronised before use
    logic slow_sync1_r;
    logic slow_sync2_r;
    logic slow_prev_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_sync1_r <= 1'b0;
            slow_sync2_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end else begin
            slow_sync1_r <= lcd_slow_clk;
            slow_sync2_r <= slow_sync1_r;
            slow_prev_r <= slow_sync2_r;
        end
    end
    wire slow_tick = slow_sync2_r && !slow_prev_r;

    // Tick counter and active common; a rate change takes effect at once, in the period under way
    logic [3:0] tick_cnt_r;
    logic [1:0] active_common_r;
    logic wave_step_r;
    logic frame_start_r;
    wire tick_wrap = slow_tick && (tick_cnt_r >= 4'(wave_div - 4'h1));
    wire com_wrap = tick_wrap && (active_common_r >= last_common);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 4'h0;
            active_common_r <= 2'h0;
            wave_step_r <= 1'b0;
            frame_start_r <= 1'b0;
        end else if (!rate_valid) begin
            tick_cnt_r <= 4'h0;
            active_common_r <= 2'h0;
            wave_step_r <= 1'b0;
            frame_start_r <= 1'b0;
        end else begin
            wave_step_r <= tick_wrap;
            frame_start_r <= com_wrap;
            if (tick_wrap) begin
                tick_cnt_r <= 4'h0;
                active_common_r <= com_wrap ? 2'h0 : 2'(active_common_r + 2'h1);
            end else if (slow_tick) begin
                tick_cnt_r <= 4'(tick_cnt_r + 4'h1);
            end
        end
    end

    assign wave_step = wave_step_r;
    assign frame_start = frame_start_r;
    assign active_common = active_common_r;
endmodule

/* bench/lsm_display_setup_monitor.sv */
// Port checker of the display setup block
`timescale 1ns/1ps
module lsm_display_setup_monitor
    import lsm_pkg::*;
#(
    parameter int SEG_PINS = LSM_SEG_PINS
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [LSM_ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic [7:0] disp_data,
    input logic [SEG_PINS-1:0] seg_pin_select,
    input logic common_line_two,
    input logic common_line_three,
    input logic segment_line_28,
    input logic slow_clock_select,
    input logic [1:0] common_count_field,
    input logic [3:0] frame_rate_code,
    input logic [3:0] wave_div,
    input logic [4:0] frame_div
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write strobes per register, taken at the access edge
    wire wr_any = psel && penable && pwrite;
    wire wr_cfg = wr_any && paddr[11:2] == LSM_IDX_CONFIG;
    wire wr_hi = wr_any && paddr[11:2] == LSM_IDX_SEG_HIGH;
    wire wr_lo = wr_any && paddr[11:2] == LSM_IDX_SEG_LOW;
    wire [3:0] fd = frame_rate_code;
    wire [2:0] ncom = common_count_field[1] ? {1'b0, common_count_field} + 3'h1 : 3'h2;

    fixed_segs_a: assert property (seg_pin_select[15:0] == 16'hffff)
        else $error("fixed segments off");
    high_sel_a: assert property (wr_hi |=> seg_pin_select[25:20] == $past(pwdata[7:2]))
        else $error("high select wrong");
    low_sel_a: assert property (wr_lo |=> seg_pin_select[19:16] == $past(pwdata[3:0]))
        else $error("low select wrong");
    slow_sel_a: assert property (wr_cfg |=> slow_clock_select == $past(pwdata[3]))
        else $error("clock select wrong");
    com_two_a: assert property (common_line_two == common_count_field[1]
        && segment_line_28 == !common_line_two) else $error("pin 28 role wrong");
    com_three_a: assert property (common_line_three == (common_count_field == LSM_MUX_FOUR))
        else $error("pin 27 role wrong");
    two_com_a: assert property (slow_clock_select && !common_count_field[1] |->
        wave_div == (fd == 4'h1 ? LSM_DIV_32 : fd == 4'h2 ? LSM_DIV_21 : fd == 4'hf ?
        LSM_DIV_128 : fd == 4'h0 ? LSM_DIV_64 : LSM_DIV_16)) else $error("two common rate");
    many_com_a: assert property (slow_clock_select && common_count_field[1] |->
        wave_div == (fd == 4'hf ? LSM_DIV_128 : fd == 4'h0 ? LSM_DIV_64 : LSM_DIV_32))
        else $error("multi common rate");
    frame_len_a: assert property (slow_clock_select |-> frame_div == {1'b0, wave_div} * ncom)
        else $error("frame length wrong");
    clear_mem_a: assert property (wr_cfg && pwdata[LSM_CFG_CLEAR_BIT] |-> ##3 disp_data == 8'h00)
        else $error("memory not cleared");
    reset_mem_a: assert property ($rose(presetn) |-> disp_data == 8'h00)
        else $error("memory not reset");
    bus_answer_a: assert property (psel && penable |-> pready && prdata[31:8] == 24'h0)
        else $error("bad bus answer");
    // Main scenarios reached
    cover property (wr_cfg && pwdata[LSM_CFG_CLEAR_BIT]);
    cover property (common_line_three && slow_clock_select);
    cover property (wr_hi && pwdata[7:2] != 6'h00);
endmodule

bind lsm_display_setup lsm_display_setup_monitor #(.SEG_PINS(SEG_PINS)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .disp_data(disp_data),
    .seg_pin_select(seg_pin_select), .common_line_two(common_line_two),
    .common_line_three(common_line_three), .segment_line_28(segment_line_28),
    .slow_clock_select(slow_clock_select), .common_count_field(common_count_field),
    .frame_rate_code(frame_rate_code), .wave_div(wave_div), .frame_div(frame_div)
);

/* bench/lsm_glass_model.sv */
// Glass model that sweeps display memory and counts its commons
`timescale 1ns/1ps
module lsm_glass_model
    import lsm_pkg::*;
(
    input logic pclk,
    input logic presetn,
    input logic [1:0] view_screen,
    input logic [7:0] disp_data,
    input logic common_line_two,
    input logic common_line_three,
    output logic [1:0] disp_screen,
    output logic [3:0] disp_addr,
    output logic [7:0] seen [LSM_BYTES],
    output logic [2:0] commons
);
    // Shared pins add commons only when turned over
    assign commons = 3'h2 + {2'h0, common_line_two} + {2'h0, common_line_three};
    assign disp_screen = view_screen;
    // One byte a cycle; address 15 is never asked, it holds no segments
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_addr <= 4'h0;
        end else begin
            seen[disp_addr] <= disp_data;
            disp_addr <= (disp_addr == LSM_LAST_ADDR) ? 4'h0 : disp_addr + 4'h1;
        end
    end
endmodule

/* bench/lsm_display_setup_tb.sv */
// Self-checking bench of the display setup block
`timescale 1ns/1ps
module lsm_display_setup_tb
    import lsm_pkg::*;
;
    typedef struct packed {logic [7:0] cfg; logic [3:0] fd; logic [3:0] wave;} lsm_row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [LSM_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, err, lcd_slow_clk = 1'b0;
    logic [1:0] view_screen = 2'h0, disp_screen, common_count_field, active_common;
    logic [3:0] disp_addr, wave_div, frame_rate_code, blink_config;
    logic [7:0] disp_data, rd;
    logic [7:0] seen [LSM_BYTES];
    logic [25:0] seg_pin_select;
    logic common_line_two, common_line_three, segment_line_28, segment_line_27;
    logic slow_clock_select, bias_select, rate_valid, wave_step, frame_start;
    logic [4:0] frame_div;
    logic [2:0] commons, ncom;
    int errors = 0, total_checks = 0, cyc = 0, steps = 0, frames = 0, s0, f0;
    logic [9:0] regs [6] = '{LSM_IDX_CONFIG, LSM_IDX_FRAME, LSM_IDX_SEG_HIGH,
        LSM_IDX_POINTER, LSM_IDX_DATA, LSM_IDX_SEG_LOW};
    lsm_row_s rows [12] = '{'{8'h08, 4'h1, 4'h4}, '{8'h08, 4'h2, 4'h6}, '{8'h08, 4'hf, 4'h1},
        '{8'h08, 4'h0, 4'h2}, '{8'h08, 4'h5, 4'h8}, '{8'h09, 4'h3, 4'h8}, '{8'h0e, 4'h1, 4'h4},
        '{8'h0a, 4'hf, 4'h1}, '{8'h0a, 4'h0, 4'h2}, '{8'h0f, 4'h2, 4'h4}, '{8'h0b, 4'hf, 4'h1},
        '{8'h0b, 4'h0, 4'h2}};

    lsm_display_setup u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .lcd_slow_clk, .disp_screen, .disp_addr, .disp_data,
        .seg_pin_select, .common_line_two, .common_line_three, .segment_line_28,
        .segment_line_27, .slow_clock_select, .bias_select, .common_count_field,
        .frame_rate_code, .blink_config, .rate_valid, .wave_div, .frame_div, .wave_step,
        .frame_start, .active_common);
    lsm_glass_model u_glass (.pclk, .presetn, .view_screen, .disp_data, .common_line_two,
        .common_line_three, .disp_screen, .disp_addr, .seen, .commons);

    always #20 pclk = ~pclk;
    // Slow clock far above 128 Hz so a frame fits in a short run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc % 10 == 0) lcd_slow_clk <= ~lcd_slow_clk;
        if (wave_step === 1'b1) steps <= steps + 1;
        if (frame_start === 1'b1) frames <= frames + 1;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Setup cycle, then access held until pready is seen high
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        chk({err, rd}, {1'b0, exp});
    endtask
    // Data first, then pointer with the write bit, as software must
    task automatic mem_wr(input logic [7:0] ptr, input logic [7:0] d);
        apb(LSM_IDX_DATA, 1'b1, d);
        apb(LSM_IDX_POINTER, 1'b1, ptr | 8'h80);
    endtask
    task automatic mem_rd(input logic [7:0] ptr, input logic [7:0] exp);
        apb(LSM_IDX_POINTER, 1'b1, ptr);
        rdchk(LSM_IDX_DATA, exp);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        foreach (seen[i]) chk(seen[i], 8'h00);
        foreach (regs[i]) rdchk(regs[i], 8'h00);
        chk(seg_pin_select, 26'h000ffff);
        foreach (rows[i]) begin
            apb(LSM_IDX_CONFIG, 1'b1, rows[i].cfg);
            apb(LSM_IDX_FRAME, 1'b1, {rows[i].fd, rows[i].fd});
            @(negedge pclk);
            ncom = rows[i].cfg[1] ? rows[i].cfg[1:0] + 3'h1 : 3'h2;
            chk(wave_div, rows[i].wave);
            chk(frame_div, rows[i].wave * ncom);
            chk(commons, ncom);
            chk({rate_valid, segment_line_27}, {1'b1, rows[i].cfg[1:0] != 2'h3});
            chk({bias_select, blink_config}, {rows[i].cfg[2], rows[i].fd});
        end
        // Waveform pace: four commons, code 0 gives a step every two ticks
        @(negedge pclk) s0 = steps;
        f0 = frames;
        repeat (400) @(posedge pclk);
        chk(steps - s0 >= 9 && steps - s0 <= 11, 1);
        chk(frames - f0 >= 2 && frames - f0 <= 3, 1);
        apb(LSM_IDX_CONFIG, 1'b1, 8'h03);
        // A step launched at the write edge is still counted; let it pass first
        repeat (2) @(negedge pclk);
        s0 = steps;
        chk({slow_clock_select, rate_valid}, 2'h0);
        repeat (200) @(posedge pclk);
        chk(steps - s0 + active_common, 0);
        // Unmapped word is refused and reads zero
        apb(10'h0a0, 1'b1, 8'hff);
        apb(10'h0a0, 1'b0, 8'h00);
        chk({err, rd}, 9'h100);
        // Sparse pin selection, reserved bits dropped
        apb(LSM_IDX_SEG_HIGH, 1'b1, 8'h54);
        apb(LSM_IDX_SEG_LOW, 1'b1, 8'hf5);
        rdchk(LSM_IDX_SEG_LOW, 8'h05);
        chk(seg_pin_select, {6'h15, 4'h5, 16'hffff});
        mem_wr(8'h12, 8'ha5);
        mem_wr(8'h3e, 8'h3c);
        mem_wr(8'h0f, 8'h77);
        mem_rd(8'h52, 8'ha5);
        rdchk(LSM_IDX_POINTER, 8'h12);
        mem_rd(8'h02, 8'h00);
        mem_rd(8'h3e, 8'h3c);
        mem_rd(8'h0f, 8'h00);
        @(posedge pclk) view_screen <= 2'h1;
        repeat (20) @(posedge pclk);
        chk(seen[2], 8'ha5);
        // Clear action leaves the other config bits stored
        apb(LSM_IDX_CONFIG, 1'b1, 8'h4b);
        rdchk(LSM_IDX_CONFIG, 8'h0b);
        mem_rd(8'h12, 8'h00);
        mem_rd(8'h3e, 8'h00);
        // Second reset in mid-run
        mem_wr(8'h05, 8'h99);
        apb(LSM_IDX_SEG_HIGH, 1'b1, 8'hfc);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(seg_pin_select, 26'h000ffff);
        mem_rd(8'h05, 8'h00);
        print_verdict();
    end
endmodule
